// [rtl/audio_dac_mute_pkg.sv]
package audio_dac_mute_pkg;

	// ==========================================
	// Register map (word offsets on the plain port)
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_ATT = 4'h1;
	localparam logic [3:0] OFS_STATUS = 4'h2;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h3;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h4;

	// ==========================================
	// Control word, bit 0 is softMute
	typedef struct packed {
		logic bassBoostLevel;
		logic bassBoostEnable;
		logic mutePolarity;
		logic decoderSpeed;
		logic dacClockSelect;
		logic wordClockResync;
		logic dcOffset;
		logic zeroMuteEn;
		logic outputSelect;
		logic forcedMute;
		logic softMute;
	} ctrl_s;
	localparam int CTRL_W = 11;
	localparam logic [10:0] CTRL_RESET = 11'h000;

	// Serial audio pins
	typedef struct packed {
		logic bitClk;
		logic wordClk;
		logic data;
	} link_s;

	typedef enum logic [1:0] {
		SYNC_HUNT = 2'b00,
		SYNC_HOLD = 2'b01,
		SYNC_LOCKED = 2'b10
	} sync_e;

	// ==========================================
	// Fields and widths
	localparam int ATT_W = 10;
	localparam logic [9:0] ATT_RESET = 10'h3ff;
	localparam logic [9:0] ATT_MUTE = 10'h000;
	localparam int SAMPLE_W = 16;
	localparam int ZERO_DC_BITS = 4;
	localparam int BITS_PER_FRAME = 48;
	localparam int IRQ_W = 4;
	localparam int IRQ_ZERO_L = 0;
	localparam int IRQ_ZERO_R = 1;
	localparam int IRQ_ALIGN = 2;
	localparam int IRQ_ATT_DONE = 3;
	localparam logic [3:0] IRQ_RESET = 4'h0;
	localparam int ST_ZERO_L = 0;
	localparam int ST_ZERO_R = 1;
	localparam int ST_ALIGNED = 2;
	localparam int ST_DOUBLE = 3;
	localparam int ST_FMUTE = 4;
	localparam int ST_ATT_LSB = 16;

	// ==========================================
	// Timing
	localparam int CLK_HZ = 40_000_000;
	localparam int ZERO_TIME_MS = 300;
	localparam int ZERO_CYCLES = ZERO_TIME_MS * (CLK_HZ / 1000);
	localparam int ATT_STEP_CYCLES = 64;
	localparam int BOOST_LP_SHIFT = 4;
	localparam int BOOST_MID_SHIFT = 2;
	localparam int BOOST_MAX_SHIFT = 1;

endpackage

// [rtl/audio_dac_mute_control.sv]
// Behaviour
// RQ1: Flag a channel zero after ~300 ms of upper bits all equal, low nibble ignored.
// RQ2: Left and right have their own zero detectors, each seeing only its samples.
// RQ3: Mute flag asserts on zero data, system mute pin high, or soft mute.
// RQ4: Mute flag polarity follows the polarity control bit.
// RQ5: New attenuation target mid-ramp: ramp from current level toward new one.
// RQ6: Ramp to zero on attenuation zero, soft mute or system mute pin.
// RQ7: Forced mute holds the PWM streams low.
// RQ8: Controller sets output select together with forced mute or resync.
// RQ9: Forced mute also when zero mute enabled and both channels zero.
// RQ10: Controller sets DC offset control when it enables zero mute.
// RQ11: Framing aligns on the first word clock falling edge after reset.
// RQ12: Controller resyncs after crystal, decoder speed or DAC clock changes.
// RQ13: Resync bit set for a word clock period then cleared; realign on release.
// RQ14: Double speed only with 768Fs crystal and DAC clock select low.
// RQ15: DAC speed ignores the decoder speed bit.
// RQ16: Bass boost off, medium or maximum from two control bits.
// RQ17: 48 bit clocks per frame, MSB first, word clock high is left.
// RQ18: A breaking sample restarts the interval and clears zero state.
// RQ19: Mute flag goes inactive once no condition holds.
//
// Implementation choices: the strobed register port and the placing of the registers.
module audio_dac_mute_control #(
	parameter int ZERO_CYCLES = audio_dac_mute_pkg::ZERO_CYCLES,
	parameter int ATT_STEP_CYCLES = audio_dac_mute_pkg::ATT_STEP_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clockEnable,
	// Register port
	input wire logic [audio_dac_mute_pkg::ADDR_W-1:0] regAddr,
	input wire logic [audio_dac_mute_pkg::DATA_W-1:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [audio_dac_mute_pkg::DATA_W-1:0] regReadData,
	// Pins
	input wire audio_dac_mute_pkg::link_s serialIn,
	input wire logic system_mute_pin,
	input wire logic crystal_ratio_pin,
	// Outputs
	output logic left_mute_flag,
	output logic right_mute_flag,
	output logic pwmLeft,
	output logic pwmRight,
	output logic dacDoubleSpeed,
	output logic decoder_speed_select,
	output logic output_select_bit,
	output logic dc_offset_ctl,
	output logic interrupt
);

	localparam int SW = audio_dac_mute_pkg::SAMPLE_W;
	localparam int AW = audio_dac_mute_pkg::ATT_W;

	function automatic logic zeroCond(input logic [SW-1:0] s);
		logic [SW-audio_dac_mute_pkg::ZERO_DC_BITS-1:0] hi;
		hi = s[SW-1:audio_dac_mute_pkg::ZERO_DC_BITS];
		return (&hi) || !(|hi);
	endfunction

	function automatic logic signed [SW-1:0] sat(input logic signed [SW+1:0] v);
		logic signed [SW+1:0] maxV;
		maxV = (SW+2)'(2**(SW-1) - 1);
		if (v > maxV)
			return SW'(maxV);
		else if (v < -maxV - 1)
			return SW'(-maxV - 1);
		return v[SW-1:0];
	endfunction

	// ==========================================
	// Pin synchronisers, the third stage only feeds edge detection
	logic [2:0] bitSync;
	logic [2:0] wordSync;
	logic [1:0] dataSync;
	logic [1:0] sysSync;
	logic [1:0] xtalSync;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			bitSync <= 3'h0;
			wordSync <= 3'h0;
			dataSync <= 2'h0;
			sysSync <= 2'h0;
			xtalSync <= 2'h0;
		end else if (clockEnable) begin
			bitSync <= {bitSync[1:0], serialIn.bitClk};
			wordSync <= {wordSync[1:0], serialIn.wordClk};
			dataSync <= {dataSync[0], serialIn.data};
			sysSync <= {sysSync[0], system_mute_pin};
			xtalSync <= {xtalSync[0], crystal_ratio_pin};
		end
	end

	logic bitRise;
	logic wordFall;
	logic wordRise;
	logic sysMute;
	assign bitRise = bitSync[1] && !bitSync[2];
	assign wordFall = !wordSync[1] && wordSync[2];
	assign wordRise = wordSync[1] && !wordSync[2];
	assign sysMute = sysSync[1];

	// ==========================================
	// Registers
	audio_dac_mute_pkg::ctrl_s ctrl;
	logic [AW-1:0] attTarget;
	logic [audio_dac_mute_pkg::IRQ_W-1:0] irqStat;
	logic [audio_dac_mute_pkg::IRQ_W-1:0] irqMask;
	logic [audio_dac_mute_pkg::IRQ_W-1:0] irqEvent;
	logic [AW-1:0] attLevel;
	logic [1:0] zeroFlag;
	logic forcedActive;
	audio_dac_mute_pkg::sync_e syncState;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ctrl <= audio_dac_mute_pkg::CTRL_RESET;
			attTarget <= audio_dac_mute_pkg::ATT_RESET;
			irqMask <= audio_dac_mute_pkg::IRQ_RESET;
		end else if (clockEnable && regWrite) begin
			if (regAddr == audio_dac_mute_pkg::OFS_CTRL)
				ctrl <= regWriteData[audio_dac_mute_pkg::CTRL_W-1:0];
			if (regAddr == audio_dac_mute_pkg::OFS_ATT)
				attTarget <= regWriteData[AW-1:0];
			if (regAddr == audio_dac_mute_pkg::OFS_IRQ_MASK)
				irqMask <= regWriteData[audio_dac_mute_pkg::IRQ_W-1:0];
		end
	end

	// Set wins over the write-one clear so no event is lost
	always_ff @(posedge clock) begin
		if (!reset_n)
			irqStat <= audio_dac_mute_pkg::IRQ_RESET;
		else if (clockEnable) begin
			if (regWrite && regAddr == audio_dac_mute_pkg::OFS_IRQ_STAT)
				irqStat <= (irqStat & ~regWriteData[audio_dac_mute_pkg::IRQ_W-1:0]) | irqEvent;
			else
				irqStat <= irqStat | irqEvent;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n)
			interrupt <= 1'b0;
		else if (clockEnable)
			interrupt <= |(irqStat & irqMask);
	end

	always_ff @(posedge clock) begin
		if (!reset_n)
			regReadData <= 32'h0000_0000;
		else if (clockEnable) begin
			regReadData <= 32'h0000_0000;
			if (regRead) begin
				unique case (regAddr)
					audio_dac_mute_pkg::OFS_CTRL: regReadData <= 32'(ctrl);
					audio_dac_mute_pkg::OFS_ATT: regReadData <= 32'(attTarget);
					audio_dac_mute_pkg::OFS_STATUS: begin
						regReadData[audio_dac_mute_pkg::ST_ZERO_L] <= zeroFlag[0];
						regReadData[audio_dac_mute_pkg::ST_ZERO_R] <= zeroFlag[1];
						regReadData[audio_dac_mute_pkg::ST_ALIGNED] <= syncState == audio_dac_mute_pkg::SYNC_LOCKED;
						regReadData[audio_dac_mute_pkg::ST_DOUBLE] <= dacDoubleSpeed;
						regReadData[audio_dac_mute_pkg::ST_FMUTE] <= forcedActive;
						regReadData[audio_dac_mute_pkg::ST_ATT_LSB +: AW] <= attLevel;
					end
					audio_dac_mute_pkg::OFS_IRQ_STAT: regReadData <= 32'(irqStat);
					audio_dac_mute_pkg::OFS_IRQ_MASK: regReadData <= 32'(irqMask);
					default: regReadData <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================
	// Word clock alignment
	always_ff @(posedge clock) begin
		if (!reset_n)
			syncState <= audio_dac_mute_pkg::SYNC_HUNT; // RQ11
		else if (clockEnable) begin
			unique case (syncState)
				audio_dac_mute_pkg::SYNC_HUNT:
					if (ctrl.wordClockResync)
						syncState <= audio_dac_mute_pkg::SYNC_HOLD;
					else if (wordFall)
						syncState <= audio_dac_mute_pkg::SYNC_LOCKED; // RQ11
				audio_dac_mute_pkg::SYNC_HOLD:
					if (!ctrl.wordClockResync)
						syncState <= audio_dac_mute_pkg::SYNC_HUNT; // RQ13
				audio_dac_mute_pkg::SYNC_LOCKED:
					if (ctrl.wordClockResync)
						syncState <= audio_dac_mute_pkg::SYNC_HOLD; // RQ13
				default: syncState <= audio_dac_mute_pkg::SYNC_HUNT;
			endcase
		end
	end

	// ==========================================
	// Serial capture: the last SW bits before each word clock edge
	logic [SW-1:0] shifter;
	logic [SW-1:0] sample [2];
	logic [1:0] newSample;
	logic locked;
	assign locked = syncState == audio_dac_mute_pkg::SYNC_LOCKED;

	always_ff @(posedge clock) begin
		if (!reset_n)
			shifter <= 16'h0000;
		else if (clockEnable && bitRise)
			shifter <= {shifter[SW-2:0], dataSync[1]}; // RQ17
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sample[0] <= 16'h0000;
			sample[1] <= 16'h0000;
			newSample <= 2'h0;
		end else if (clockEnable) begin
			newSample <= {locked && wordRise, locked && wordFall};
			if (locked && wordFall)
				sample[0] <= shifter; // RQ17
			if (locked && wordRise)
				sample[1] <= shifter;
		end
	end

	// ==========================================
	// Attenuation ramp, one step per interval from the present level
	logic [AW-1:0] effTarget;
	logic [$clog2(ATT_STEP_CYCLES+1)-1:0] stepCount;
	logic softMuting;
	assign softMuting = attTarget == audio_dac_mute_pkg::ATT_MUTE || ctrl.softMute || sysMute;
	assign effTarget = softMuting ? audio_dac_mute_pkg::ATT_MUTE : attTarget; // RQ6

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			attLevel <= audio_dac_mute_pkg::ATT_RESET;
			stepCount <= '0;
		end else if (clockEnable) begin
			if (stepCount == ($bits(stepCount))'(ATT_STEP_CYCLES - 1)) begin
				stepCount <= '0;
				if (attLevel < effTarget)
					attLevel <= attLevel + 1'b1; // RQ5
				else if (attLevel > effTarget)
					attLevel <= attLevel - 1'b1; // RQ5
			end else
				stepCount <= stepCount + 1'b1;
		end
	end

	assign irqEvent[audio_dac_mute_pkg::IRQ_ALIGN] = syncState == audio_dac_mute_pkg::SYNC_HUNT && wordFall
		&& !ctrl.wordClockResync;
	assign irqEvent[audio_dac_mute_pkg::IRQ_ATT_DONE] = stepCount == ($bits(stepCount))'(ATT_STEP_CYCLES - 1)
		&& attLevel != effTarget && (attLevel + 1'b1 == effTarget || attLevel - 1'b1 == effTarget);

	// Forced mute, direct or from zero data on both channels
	assign forcedActive = ctrl.forcedMute || (ctrl.zeroMuteEn && (&zeroFlag)); // RQ7 RQ9

	// ==========================================
	// Per-channel datapath
	logic [1:0] muteCond;
	logic [1:0] pwmBit;

	for (genvar c = 0; c < 2; c++) begin : g_chan
		logic [$clog2(ZERO_CYCLES+1)-1:0] zeroCount;
		logic condHeld;
		logic signed [SW-1:0] lowPass;
		logic signed [SW-1:0] boosted;
		logic signed [SW+1:0] boostSum;
		logic signed [SW+AW:0] product;
		logic [SW:0] modAcc;
		logic [SW:0] next_modAcc;

		// Detection only ever looks at this channel's samples
		always_ff @(posedge clock) begin
			if (!reset_n) begin
				condHeld <= 1'b0;
				zeroCount <= '0;
				zeroFlag[c] <= 1'b0;
			end else if (clockEnable) begin
				if (newSample[c] && !zeroCond(sample[c])) begin
					condHeld <= 1'b0; // RQ18
					zeroCount <= '0;
					zeroFlag[c] <= 1'b0;
				end else if (newSample[c] && !condHeld) begin
					condHeld <= 1'b1; // RQ2
					zeroCount <= '0;
				end else if (condHeld && !zeroFlag[c]) begin
					if (zeroCount == ($bits(zeroCount))'(ZERO_CYCLES - 1))
						zeroFlag[c] <= 1'b1; // RQ1
					else
						zeroCount <= zeroCount + 1'b1;
				end
			end
		end

		assign irqEvent[c] = condHeld && !zeroFlag[c] && zeroCount == ($bits(zeroCount))'(ZERO_CYCLES - 1)
			&& !(newSample[c] && !zeroCond(sample[c]));

		// Bass boost adds back a low-passed copy of the signal
		always_ff @(posedge clock) begin
			if (!reset_n)
				lowPass <= 16'h0000;
			else if (clockEnable && newSample[c])
				lowPass <= lowPass + SW'(($signed(sample[c]) - lowPass) >>> audio_dac_mute_pkg::BOOST_LP_SHIFT);
		end

		always_comb begin
			boostSum = (SW+2)'($signed(sample[c]));
			if (ctrl.bassBoostEnable) begin // RQ16
				if (ctrl.bassBoostLevel)
					boostSum = boostSum + (SW+2)'(lowPass >>> audio_dac_mute_pkg::BOOST_MAX_SHIFT);
				else
					boostSum = boostSum + (SW+2)'(lowPass >>> audio_dac_mute_pkg::BOOST_MID_SHIFT);
			end
		end

		assign boosted = sat(boostSum);
		assign product = (SW+AW+1)'(boosted * $signed({1'b0, attLevel}));

		// First-order modulator: the carry is the 1-bit stream
		assign next_modAcc = {1'b0, modAcc[SW-1:0]} + {1'b0, product[SW+AW-1:AW] ^ 16'h8000};

		always_ff @(posedge clock) begin
			if (!reset_n) begin
				modAcc <= 17'h0_0000;
				pwmBit[c] <= 1'b0;
			end else if (clockEnable) begin
				modAcc <= next_modAcc;
				pwmBit[c] <= forcedActive ? 1'b0 : next_modAcc[SW]; // RQ7
			end
		end

		assign muteCond[c] = zeroFlag[c] || sysMute || ctrl.softMute; // RQ3
	end

	assign pwmLeft = pwmBit[0];
	assign pwmRight = pwmBit[1];

	// ==========================================
	// Flags and speed outputs
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			left_mute_flag <= 1'b1;
			right_mute_flag <= 1'b1;
		end else if (clockEnable) begin
			left_mute_flag <= muteCond[0] ~^ ctrl.mutePolarity; // RQ4 RQ19
			right_mute_flag <= muteCond[1] ~^ ctrl.mutePolarity; // RQ4 RQ19
		end
	end

	// Crystal high means 768Fs; 384Fs with select high is undefined, kept normal
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			dacDoubleSpeed <= 1'b0;
			decoder_speed_select <= 1'b0;
			output_select_bit <= 1'b0;
			dc_offset_ctl <= 1'b0;
		end else if (clockEnable) begin
			dacDoubleSpeed <= xtalSync[1] && !ctrl.dacClockSelect; // RQ14 RQ15
			decoder_speed_select <= ctrl.decoderSpeed;
			output_select_bit <= ctrl.outputSelect;
			dc_offset_ctl <= ctrl.dcOffset;
		end
	end

endmodule // audio_dac_mute_control

// [verification/audio_dac_mute_control_sva.sv]
module audio_dac_mute_control_sva (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clockEnable,
	// Register port
	input wire logic [audio_dac_mute_pkg::ADDR_W-1:0] regAddr,
	input wire logic [audio_dac_mute_pkg::DATA_W-1:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [audio_dac_mute_pkg::DATA_W-1:0] regReadData,
	// Pins
	input wire logic system_mute_pin,
	input wire logic crystal_ratio_pin,
	// Outputs
	input wire logic left_mute_flag,
	input wire logic right_mute_flag,
	input wire logic pwmLeft,
	input wire logic pwmRight,
	input wire logic dacDoubleSpeed,
	input wire logic decoder_speed_select,
	input wire logic output_select_bit,
	input wire logic dc_offset_ctl,
	input wire logic interrupt
);
	// ==========================================
	// Shadow of the control word, rebuilt from bus writes
	audio_dac_mute_pkg::ctrl_s ctrl;
	always_ff @(posedge clock) begin
		if (!reset_n)
			ctrl <= '0;
		else if (clockEnable && regWrite && regAddr == audio_dac_mute_pkg::OFS_CTRL)
			ctrl <= regWriteData[10:0];
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	// ==========================================
	// Properties
	chk_read_idle: assert property ($past(clockEnable) && !$past(regRead) |-> regReadData == '0)
		else $error("read data not zero outside read cycle");
	chk_ctrl_read: assert property (clockEnable && regRead && regAddr == 4'h0 |=> regReadData == {21'h0, ctrl})
		else $error("control readback wrong");
	chk_unmapped_read: assert property (clockEnable && regRead && regAddr > 4'h4 |=> regReadData == '0)
		else $error("unmapped read not zero");
	chk_soft_flags: assert property (ctrl.softMute && $stable(ctrl) |->
		left_mute_flag == ctrl.mutePolarity && right_mute_flag == ctrl.mutePolarity)
		else $error("soft mute flags wrong");
	chk_sys_flags: assert property ((system_mute_pin && $stable(ctrl))[*5] |->
		left_mute_flag == ctrl.mutePolarity && right_mute_flag == ctrl.mutePolarity)
		else $error("system mute flags wrong");
	chk_fmute_pwm: assert property (ctrl.forcedMute && $past(ctrl.forcedMute) |-> !pwmLeft && !pwmRight)
		else $error("pwm not low in forced mute");
	chk_speed_map: assert property (($stable(crystal_ratio_pin) && $stable(ctrl))[*5] |->
		dacDoubleSpeed == (crystal_ratio_pin && !ctrl.dacClockSelect))
		else $error("dac speed wrong");
	chk_ctrl_copies: assert property ($stable(ctrl) |-> output_select_bit == ctrl.outputSelect &&
		dc_offset_ctl == ctrl.dcOffset && decoder_speed_select == ctrl.decoderSpeed)
		else $error("control copy outputs wrong");
	chk_irq_masked: assert property (clockEnable && regWrite && regAddr == 4'h4 && regWriteData[3:0] == 4'h0
		##1 (!regWrite && clockEnable)[*2] |-> !interrupt)
		else $error("interrupt high with mask clear");
endmodule // audio_dac_mute_control_sva

// [verification/audio_source_model.sv]
module audio_source_model (
	// Samples to send
	input wire logic [15:0] leftSample,
	input wire logic [15:0] rightSample,
	// Serial link
	output audio_dac_mute_pkg::link_s link
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [47:0] frame;

	// ==========================================
	// Frames run back to back, so the bit clock never pauses
	initial begin
		link = '0;
		forever begin
			frame = {{8{leftSample[15]}}, leftSample, {8{rightSample[15]}}, rightSample};
			for (int i = 47; i >= 0; i--) begin
				link.bitClk = 1'b0;
				link.wordClk = (i > 23);
				link.data = frame[i];
				#100 link.bitClk = 1'b1;
				#100;
			end
		end
	end
endmodule // audio_source_model

// [verification/audio_dac_mute_control_bench.sv]
module audio_dac_mute_control_bench;
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================
	// Signals
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWriteData = 32'h0000_0000;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] regReadData;
	audio_dac_mute_pkg::link_s serialIn;
	logic sysMute = 1'b0;
	logic xtal = 1'b0;
	logic clkEn = 1'b1;
	logic [15:0] leftSample = 16'h1234;
	logic [15:0] rightSample = 16'h4321;
	logic leftFlag, rightFlag, pwmLeft, pwmRight, dblSpeed, decSpeed, outSel, dcOff, irq;
	int error_cnt = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic [31:0] ones;
	logic [9:0] lvl;

	always #12.5 clock = ~clock;

	audio_source_model src_u (.leftSample(leftSample), .rightSample(rightSample), .link(serialIn));

	audio_dac_mute_control #(.ZERO_CYCLES(200), .ATT_STEP_CYCLES(4)) dut_u (
		.clock(clock), .reset_n(reset_n), .clockEnable(clkEn),
		.regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
		.regReadData(regReadData), .serialIn(serialIn), .system_mute_pin(sysMute),
		.crystal_ratio_pin(xtal), .left_mute_flag(leftFlag), .right_mute_flag(rightFlag),
		.pwmLeft(pwmLeft), .pwmRight(pwmRight), .dacDoubleSpeed(dblSpeed),
		.decoder_speed_select(decSpeed), .output_select_bit(outSel), .dc_offset_ctl(dcOff),
		.interrupt(irq));

	// ==========================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string msg);
		num_checks++;
		if (seen !== want) begin
			error_cnt++;
			$display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, want);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
		@(posedge clock);
	endtask

	// Read data is taken mid-cycle, the only cycle it stands
	task automatic rdreg(input logic [3:0] a, output logic [31:0] d);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		@(negedge clock);
		d = regReadData;
		@(posedge clock);
	endtask

	task automatic pwmOnes(input int n, output logic [31:0] k);
		k = 32'h0000_0000;
		repeat (n) begin
			@(negedge clock);
			k = k + pwmLeft + pwmRight;
		end
		@(posedge clock);
	endtask

	task automatic flags(input logic [31:0] want, input string msg);
		check({30'h0, leftFlag, rightFlag}, want, msg);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset();
		rdreg(4'h0, rd);
		check(rd, 32'h0000_0000, "ctrl reset");
		rdreg(4'h2, rd);
		check(rd & 32'h03ff_0000, 32'h03ff_0000, "att reset");
		rdreg(4'h9, rd);
		check(rd, 32'h0000_0000, "unmapped");
		cyc(400);
		rdreg(4'h2, rd);
		check(rd & 32'h0000_0004, 32'h0000_0004, "aligned");
		$display("test reset done");
	endtask

	task automatic t_flags();
		wr(4'h0, 32'h0000_0100);
		cyc(3);
		flags(32'h0, "idle high pol");
		wr(4'h0, 32'h0000_0101);
		cyc(3);
		flags(32'h3, "soft high pol");
		wr(4'h0, 32'h0000_0001);
		cyc(3);
		flags(32'h0, "soft low pol");
		wr(4'h0, 32'h0000_0100);
		sysMute <= 1'b1;
		cyc(6);
		flags(32'h3, "sys mute");
		sysMute <= 1'b0;
		cyc(6);
		flags(32'h0, "released");
		$display("test flags done");
	endtask

	// A frozen block must neither take a write nor answer a read
	task automatic t_enable();
		clkEn <= 1'b0;
		wr(4'h0, 32'h0000_0101);
		rdreg(4'h0, rd);
		check(rd, 32'h0000_0000, "frozen read");
		cyc(3);
		flags(32'h0, "frozen flags");
		clkEn <= 1'b1;
		rdreg(4'h0, rd);
		check(rd, 32'h0000_0100, "write ignored");
		$display("test enable done");
	endtask

	task automatic t_zero();
		pwmOnes(200, ones);
		check({31'h0, ones != 0}, 32'h1, "pwm alive");
		wr(4'h4, 32'h0000_0001);
		leftSample <= 16'h0007;
		cyc(350);
		rdreg(4'h2, rd);
		check(rd & 32'h3, 32'h0, "zero too early");
		cyc(600);
		rdreg(4'h2, rd);
		check(rd & 32'h3, 32'h1, "zero left only");
		flags(32'h2, "left flag");
		check({31'h0, irq}, 32'h1, "irq raised");
		wr(4'h4, 32'h0000_0000);
		@(negedge clock);
		check({31'h0, irq}, 32'h0, "irq masked");
		@(posedge clock);
		wr(4'h3, 32'h0000_0001);
		wr(4'h4, 32'h0000_0001);
		cyc(3);
		check({31'h0, irq}, 32'h0, "irq cleared");
		leftSample <= 16'h1234;
		cyc(700);
		rdreg(4'h2, rd);
		check(rd & 32'h1, 32'h0, "zero broken");
		leftSample <= 16'hfff3;
		rightSample <= 16'h000c;
		wr(4'h0, 32'h0000_0118);
		cyc(1000);
		rdreg(4'h2, rd);
		check(rd & 32'h13, 32'h13, "zero mute");
		pwmOnes(100, ones);
		check(ones, 32'h0, "pwm zero mute");
		leftSample <= 16'h1234;
		rightSample <= 16'h4321;
		wr(4'h0, 32'h0000_0106);
		pwmOnes(100, ones);
		check(ones, 32'h0, "pwm forced");
		check({31'h0, outSel}, 32'h1, "osel copy");
		wr(4'h0, 32'h0000_0100);
		$display("test zero done");
	endtask

	task automatic t_att();
		wr(4'h1, 32'h0000_0200);
		cyc(100);
		rdreg(4'h2, rd);
		lvl = rd[25:16];
		check({31'h0, lvl < 10'h3ff && lvl > 10'h3e0}, 32'h1, "ramp down");
		wr(4'h1, 32'h0000_03ff);
		cyc(40);
		rdreg(4'h2, rd);
		check({31'h0, rd[25:16] > lvl && rd[25:16] <= lvl + 10'h00c}, 32'h1, "ramp turn");
		wr(4'h0, 32'h0000_0101);
		cyc(4200);
		rdreg(4'h2, rd);
		check(rd & 32'h03ff_0000, 32'h0, "soft to zero");
		wr(4'h0, 32'h0000_0100);
		wr(4'h1, 32'h0000_0000);
		cyc(40);
		rdreg(4'h2, rd);
		check(rd & 32'h03ff_0000, 32'h0, "att zero");
		wr(4'h1, 32'h0000_03ff);
		$display("test att done");
	endtask

	task automatic t_speed();
		for (int i = 0; i < 8; i++) begin
			xtal <= i[0];
			wr(4'h0, {23'h0, 1'b1, i[2], i[1], 6'h00});
			cyc(6);
			check({31'h0, dblSpeed}, {31'h0, i[0] & ~i[1]}, "dac speed");
			check({31'h0, decSpeed}, {31'h0, i[2]}, "dsp bit");
		end
		xtal <= 1'b0;
		$display("test speed done");
	endtask

	task automatic t_resync();
		wr(4'h0, 32'h0000_0124);
		cyc(400);
		rdreg(4'h2, rd);
		check(rd & 32'h4, 32'h0, "held unaligned");
		wr(4'h0, 32'h0000_0104);
		cyc(500);
		rdreg(4'h2, rd);
		check(rd & 32'h4, 32'h4, "realigned");
		$display("test resync done");
	endtask

	// ==========================================
	// Run control
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			test_done();
		end
	end

	initial begin
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		t_reset();
		t_flags();
		t_enable();
		t_zero();
		t_att();
		t_speed();
		t_resync();
		test_done();
	end
endmodule // audio_dac_mute_control_bench

bind audio_dac_mute_control audio_dac_mute_control_sva chk_u (
	.clock(clock), .reset_n(reset_n), .clockEnable(clockEnable), .regAddr(regAddr),
	.regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
	.system_mute_pin(system_mute_pin), .crystal_ratio_pin(crystal_ratio_pin),
	.left_mute_flag(left_mute_flag), .right_mute_flag(right_mute_flag), .pwmLeft(pwmLeft),
	.pwmRight(pwmRight), .dacDoubleSpeed(dacDoubleSpeed), .decoder_speed_select(decoder_speed_select),
	.output_select_bit(output_select_bit), .dc_offset_ctl(dc_offset_ctl), .interrupt(interrupt));
